// [hdl/config_init_defines.svh]
/*
 * Constants of the configuration front end: pattern values, mode and port codes, width codes, timing counts.
 * Assumes the including file runs on the 250 MHz mclk.
 */
`ifndef CONFIG_INIT_DEFINES_SVH
`define CONFIG_INIT_DEFINES_SVH

`define SYNC_WORD 32'haa995566
`define WIDTH_KEY 8'hbb
`define WIDTH_X8_KEY 8'h11
`define WIDTH_X16_KEY 8'h22
`define WIDTH_X32_KEY 8'h44

`define BW_X1 2'b00
`define BW_X8 2'b01
`define BW_X16 2'b10
`define BW_X32 2'b11

`define MODE_MASTER_SERIAL 3'b000
`define MODE_SPI 3'b001
`define MODE_FLASH_UP 3'b010
`define MODE_FLASH_DOWN 3'b011
`define MODE_MASTER_PARALLEL 3'b100
`define MODE_JTAG 3'b101
`define MODE_SLAVE_PARALLEL 3'b110
`define MODE_SLAVE_SERIAL 3'b111

`define PORT_JTAG 2'b00
`define PORT_PARALLEL_SLAVE 2'b01
`define PORT_INTERNAL 2'b10

`define CLK_PERIOD_NS 4
`define POR_DELAY_NS 1000
`define PROGRAM_LATENCY_NS 400
`define POR_DELAY_CYCLES ((`POR_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROGRAM_LATENCY_CYCLES ((`PROGRAM_LATENCY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLEAR_PASS_CYCLES 64
`define CONFIG_CLOCK_HALF 4
`define INTERNAL_PORT_WIDTH 2'b11
`define BUFFER_DEPTH 2

`endif

// [hdl/config_init_pkg.sv]
/*
 * Types of the configuration front end: sequencer states and packed carriers.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package config_init_pkg;

	typedef enum logic [2:0] {
		ST_PROG_HOLD = 3'b000,
		ST_CLEAR = 3'b001,
		ST_RELEASE = 3'b010,
		ST_INIT_WAIT = 3'b011,
		ST_RUN = 3'b100
	} seq_state_t;

	typedef struct packed {
		logic programReqN;
		logic initStatusIn;
		logic configClockIn;
		logic [2:0] modeSelect;
		logic [2:0] flashReadSelect;
		logic [7:0] flashReadCommand;
		logic [31:0] configData;
	} pin_bundle_t;

	typedef struct packed {
		logic [2:0] modeSelect;
		logic [2:0] flashReadSelect;
		logic [7:0] flashReadCommand;
	} mode_capture_t;

	typedef struct packed {
		logic [31:0] data;
		logic [1:0] width;
	} config_word_t;

endpackage : config_init_pkg

// [hdl/config_init_and_sync_front_end.sv]
/*
 * Configuration front end: memory clear sequencing, init pin handling, mode capture,
 * config clock generation and edge detection, bus width detection, sync search and word output buffer.
 * Assumes pins arrive asynchronously and are synchronised here; triggers arrive on mclk.
 */
`timescale 1ns/10ps
`include "config_init_defines.svh"

module config_init_and_sync_front_end
	import config_init_pkg::*;
#(
	parameter int CLEAR_CYCLES = `CLEAR_PASS_CYCLES,
	parameter int POR_CYCLES = `POR_DELAY_CYCLES,
	parameter int LATENCY_CYCLES = `PROGRAM_LATENCY_CYCLES,
	parameter int CLOCK_HALF = `CONFIG_CLOCK_HALF,
	parameter int DEPTH = `BUFFER_DEPTH,
	parameter logic [1:0] INTERNAL_WIDTH = `INTERNAL_PORT_WIDTH
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic programReqN,
	input wire logic jtagReprogramInstr,
	input wire logic internalReprogramCmd,
	input wire logic fallbackRetry,
	input wire logic initStatusIn,
	output logic initStatusOut,
	output logic initStatusOe,
	input wire logic [2:0] modeSelect,
	input wire logic [2:0] flashReadSelect,
	input wire logic [7:0] flashReadCommand,
	input wire logic configClockIn,
	output logic configClockOut,
	output logic configClockOe,
	input wire logic [31:0] configData,
	output logic userIoHighZ,
	output logic [2:0] activeMode,
	output logic [2:0] spiFlashReadSelect,
	output logic [7:0] spiFlashReadCommand,
	input wire logic [1:0] readPort,
	output logic [1:0] detectedWidthField,
	input wire logic abortActive,
	output logic syncAlignedFlag,
	output logic linkBusy,
	output logic wordValid,
	input wire logic wordReady,
	output config_word_t wordOut
);

	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam pin_bundle_t PIN_RESET = '{programReqN: 1'b1, default: '0};

	function automatic logic isParallel(input logic [2:0] mode);
		isParallel = (mode == `MODE_FLASH_UP) || (mode == `MODE_FLASH_DOWN) ||
			(mode == `MODE_MASTER_PARALLEL) || (mode == `MODE_SLAVE_PARALLEL);
	endfunction : isParallel

	function automatic logic isMaster(input logic [2:0] mode);
		isMaster = (mode == `MODE_MASTER_SERIAL) || (mode == `MODE_SPI) || (mode == `MODE_FLASH_UP) ||
			(mode == `MODE_FLASH_DOWN) || (mode == `MODE_MASTER_PARALLEL);
	endfunction : isMaster

	function automatic logic [7:0] unswap8(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			unswap8[i] = b[7 - i];
		end
	endfunction : unswap8

	function automatic logic [31:0] unswap32(input logic [31:0] w);
		unswap32 = {unswap8(w[31:24]), unswap8(w[23:16]), unswap8(w[15:8]), unswap8(w[7:0])};
	endfunction : unswap32

	pin_bundle_t pinMeta_q;
	pin_bundle_t pinSync_q;
	logic cclkInPrev_q;
	seq_state_t state_q;
	logic [1:0] passLeft_q;
	logic porCase_q;
	logic [15:0] clearCnt_q;
	logic [15:0] delayCnt_q;
	mode_capture_t capture_q;
	logic cclkOut_q;
	logic [7:0] cclkCnt_q;
	logic keySeen_q;
	logic widthLocked_q;
	logic [1:0] width_q;
	logic syncAligned_q;
	logic [31:0] window_q;
	logic [5:0] unitCnt_q;
	config_word_t mem_q [DEPTH];
	logic [PTR_W-1:0] wrPtr_q;
	logic [PTR_W-1:0] rdPtr_q;
	logic [PTR_W:0] count_q;

	logic progLow;
	logic relock;
	logic retrigger;
	logic running;
	logic masterMode;
	logic parallelMode;
	logic cclkRun;
	logic sampleEdge;
	logic [7:0] keyByte;
	logic [1:0] effWidth;
	logic [31:0] window_d;
	logic [5:0] unitsPerWord;
	logic wordDone;
	logic pushWord;
	logic popWord;
	logic fifoInReady;

	// Pins are asynchronous to mclk; first stage feeds only the second
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pinMeta_q <= PIN_RESET;
			pinSync_q <= PIN_RESET;
			cclkInPrev_q <= 1'b0;
		end else begin
			pinMeta_q <= '{programReqN, initStatusIn, configClockIn, modeSelect, flashReadSelect,
				flashReadCommand, configData};
			pinSync_q <= pinMeta_q;
			cclkInPrev_q <= pinSync_q.configClockIn;
		end
	end

	assign progLow = !pinSync_q.programReqN;
	assign relock = progLow || jtagReprogramInstr || internalReprogramCmd;
	assign retrigger = jtagReprogramInstr || internalReprogramCmd || fallbackRetry;

	// Initialization sequencer
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_CLEAR;
			passLeft_q <= 2'd1;
			porCase_q <= 1'b1;
			clearCnt_q <= 16'h0000;
			delayCnt_q <= 16'h0000;
		end else if (progLow) begin
			state_q <= ST_PROG_HOLD;
			porCase_q <= 1'b0;
		end else if (state_q == ST_PROG_HOLD) begin
			state_q <= ST_CLEAR;
			passLeft_q <= 2'd2;
			clearCnt_q <= 16'h0000;
		end else if (retrigger) begin
			state_q <= ST_CLEAR;
			passLeft_q <= 2'd1;
			porCase_q <= 1'b0;
			clearCnt_q <= 16'h0000;
		end else begin
			case (state_q)
				ST_CLEAR: begin
					if (clearCnt_q == 16'(CLEAR_CYCLES - 1)) begin
						clearCnt_q <= 16'h0000;
						if (passLeft_q == 2'd1) begin
							state_q <= ST_RELEASE;
							delayCnt_q <= 16'h0000;
						end else begin
							passLeft_q <= passLeft_q - 2'd1;
						end
					end else begin
						clearCnt_q <= clearCnt_q + 16'h0001;
					end
				end
				ST_RELEASE: begin
					if (delayCnt_q == 16'(porCase_q ? POR_CYCLES - 1 : LATENCY_CYCLES - 1)) begin
						state_q <= ST_INIT_WAIT;
					end else begin
						delayCnt_q <= delayCnt_q + 16'h0001;
					end
				end
				ST_INIT_WAIT: begin
					if (pinSync_q.initStatusIn) begin
						state_q <= ST_RUN;
					end
				end
				default: begin
					state_q <= state_q;
				end
			endcase
		end
	end

	// Open drain: only ever pulls low
	assign initStatusOut = 1'b0;
	assign initStatusOe = (state_q == ST_PROG_HOLD) || (state_q == ST_CLEAR) || (state_q == ST_RELEASE);
	assign userIoHighZ = (state_q != ST_RUN);

	// Mode pins captured at the init rise
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			capture_q <= '0;
		end else if (state_q == ST_INIT_WAIT && pinSync_q.initStatusIn && !progLow && !retrigger) begin
			capture_q <= '{pinSync_q.modeSelect, pinSync_q.flashReadSelect, pinSync_q.flashReadCommand};
		end
	end

	assign activeMode = capture_q.modeSelect;
	assign spiFlashReadSelect = (capture_q.modeSelect == `MODE_SPI) ? capture_q.flashReadSelect : 3'b000;
	assign spiFlashReadCommand = (capture_q.modeSelect == `MODE_SPI) ? capture_q.flashReadCommand : 8'h00;

	assign running = (state_q == ST_RUN);
	assign masterMode = isMaster(capture_q.modeSelect);
	assign parallelMode = isParallel(capture_q.modeSelect);
	// Clock pauses while the buffer is full so a master source never overruns it
	assign cclkRun = running && masterMode && fifoInReady;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cclkOut_q <= 1'b0;
			cclkCnt_q <= 8'h00;
		end else if (!running || !masterMode) begin
			cclkOut_q <= 1'b0;
			cclkCnt_q <= 8'h00;
		end else if (cclkRun) begin
			if (cclkCnt_q == 8'(CLOCK_HALF - 1)) begin
				cclkCnt_q <= 8'h00;
				cclkOut_q <= !cclkOut_q;
			end else begin
				cclkCnt_q <= cclkCnt_q + 8'h01;
			end
		end
	end

	assign configClockOut = cclkOut_q;
	assign configClockOe = running && masterMode;

	// Master samples at its own rising edge, slave at the synchronised input edge
	assign sampleEdge = running && (masterMode ?
		(cclkRun && cclkCnt_q == 8'(CLOCK_HALF - 1) && !cclkOut_q) :
		(pinSync_q.configClockIn && !cclkInPrev_q));

	assign keyByte = unswap8(pinSync_q.configData[7:0]);
	assign effWidth = parallelMode ? width_q : `BW_X1;

	always_comb begin
		window_d = window_q;
		unitsPerWord = 6'd32;
		case (effWidth)
			`BW_X8: begin
				window_d = {window_q[23:0], unswap8(pinSync_q.configData[7:0])};
				unitsPerWord = 6'd4;
			end
			`BW_X16: begin
				window_d = {window_q[15:0], unswap8(pinSync_q.configData[15:8]), unswap8(pinSync_q.configData[7:0])};
				unitsPerWord = 6'd2;
			end
			`BW_X32: begin
				window_d = unswap32(pinSync_q.configData);
				unitsPerWord = 6'd1;
			end
			default: begin
				window_d = {window_q[30:0], pinSync_q.configData[0]};
				unitsPerWord = 6'd32;
			end
		endcase
	end

	// Bus width detector
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			keySeen_q <= 1'b0;
			widthLocked_q <= 1'b0;
			width_q <= `BW_X1;
		end else if (relock) begin
			keySeen_q <= 1'b0;
			widthLocked_q <= 1'b0;
			width_q <= `BW_X1;
		end else if (sampleEdge && parallelMode && !widthLocked_q) begin
			if (!keySeen_q) begin
				keySeen_q <= (keyByte == `WIDTH_KEY);
			end else if (keyByte == `WIDTH_X8_KEY) begin
				width_q <= `BW_X8;
				widthLocked_q <= 1'b1;
			end else if (keyByte == `WIDTH_X16_KEY) begin
				width_q <= `BW_X16;
				widthLocked_q <= 1'b1;
			end else if (keyByte == `WIDTH_X32_KEY) begin
				width_q <= `BW_X32;
				widthLocked_q <= 1'b1;
			end else begin
				keySeen_q <= 1'b0;
			end
		end
	end

	assign wordDone = sampleEdge && syncAligned_q && (unitCnt_q == unitsPerWord - 6'd1);
	assign pushWord = wordDone && fifoInReady;

	// Sync search and word assembly; nothing before sync leaves the block
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			syncAligned_q <= 1'b0;
			window_q <= 32'h00000000;
			unitCnt_q <= 6'd0;
		end else if (!running) begin
			syncAligned_q <= 1'b0;
			window_q <= 32'h00000000;
			unitCnt_q <= 6'd0;
		end else if (sampleEdge && (!parallelMode || widthLocked_q)) begin
			window_q <= window_d;
			if (!syncAligned_q) begin
				if (window_d == `SYNC_WORD) begin
					syncAligned_q <= 1'b1;
					unitCnt_q <= 6'd0;
				end
			end else if (unitCnt_q == unitsPerWord - 6'd1) begin
				unitCnt_q <= 6'd0;
			end else begin
				unitCnt_q <= unitCnt_q + 6'd1;
			end
		end
	end

	assign syncAlignedFlag = abortActive && (capture_q.modeSelect == `MODE_SLAVE_PARALLEL) && syncAligned_q;

	// Width status follows the reading port
	always_comb begin
		if (readPort == `PORT_JTAG) begin
			detectedWidthField = effWidth;
		end else if (readPort == `PORT_PARALLEL_SLAVE) begin
			detectedWidthField = (capture_q.modeSelect == `MODE_SLAVE_PARALLEL) ? width_q : `BW_X1;
		end else if (readPort == `PORT_INTERNAL) begin
			detectedWidthField = INTERNAL_WIDTH;
		end else begin
			detectedWidthField = `BW_X1;
		end
	end

	// Two-entry word buffer; a slave source must honour linkBusy or words drop
	assign fifoInReady = (count_q != (PTR_W + 1)'(DEPTH));
	assign linkBusy = !fifoInReady;
	assign wordValid = (count_q != '0);
	assign popWord = wordValid && wordReady;
	assign wordOut = mem_q[rdPtr_q];

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else if (pushWord) begin
			mem_q[wrPtr_q] <= '{window_d, effWidth};
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end else begin
			if (pushWord) begin
				wrPtr_q <= (wrPtr_q == PTR_W'(DEPTH - 1)) ? '0 : wrPtr_q + PTR_W'(1);
			end
			if (popWord) begin
				rdPtr_q <= (rdPtr_q == PTR_W'(DEPTH - 1)) ? '0 : rdPtr_q + PTR_W'(1);
			end
			if (pushWord && !popWord) begin
				count_q <= count_q + (PTR_W + 1)'(1);
			end else if (popWord && !pushWord) begin
				count_q <= count_q - (PTR_W + 1)'(1);
			end
		end
	end

endmodule : config_init_and_sync_front_end

// [bench/config_front_end_props.sv]
/*
 * Checker of the configuration front end ports.
 * Assumes the shared defines header; bound into the design after the module.
 */
`timescale 1ns/10ps
`include "config_init_defines.svh"

module config_front_end_props
	import config_init_pkg::*;
#(
	parameter logic [1:0] INTERNAL_WIDTH = `INTERNAL_PORT_WIDTH
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic programReqN,
	input wire logic initStatusIn,
	input wire logic initStatusOe,
	input wire logic [2:0] modeSelect,
	input wire logic configClockOe,
	input wire logic userIoHighZ,
	input wire logic [2:0] activeMode,
	input wire logic [2:0] spiFlashReadSelect,
	input wire logic [7:0] spiFlashReadCommand,
	input wire logic [1:0] readPort,
	input wire logic [1:0] detectedWidthField,
	input wire logic abortActive,
	input wire logic syncAlignedFlag,
	input wire logic wordValid,
	input wire logic wordReady,
	input wire config_word_t wordOut
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	// Pins pass two sync flops, hence the long holds
	sequence progHeld;
		(!programReqN) [*5];
	endsequence
	sequence initHeld;
		(!initStatusIn) [*3] ##1 userIoHighZ;
	endsequence

	a_prog_holds_init: assert property (progHeld |-> initStatusOe)
		else $error("init not driven during program");
	a_clear_high_z: assert property (initStatusOe |-> userIoHighZ)
		else $error("user io driven during clear");
	a_wait_init_pin: assert property (initHeld |=> userIoHighZ)
		else $error("left init while pin low");
	a_run_needs_init: assert property ($fell(userIoHighZ) |-> $past(initStatusIn, 3) || $past(initStatusIn, 4))
		else $error("run without init high");
	a_mode_capture: assert property ($fell(userIoHighZ) |-> activeMode == $past(modeSelect, 3))
		else $error("mode not captured");
	a_clock_master: assert property (configClockOe |-> !userIoHighZ && activeMode <= `MODE_MASTER_PARALLEL)
		else $error("config clock driven out of master run");
	a_spi_only: assert property (activeMode != `MODE_SPI |-> spiFlashReadSelect == 3'h0 && spiFlashReadCommand == 8'h00)
		else $error("flash fields outside spi");
	a_flag_gated: assert property (!(abortActive && activeMode == `MODE_SLAVE_PARALLEL) |-> !syncAlignedFlag)
		else $error("sync flag visible outside abort");
	a_internal_width: assert property (readPort == `PORT_INTERNAL |-> detectedWidthField == INTERNAL_WIDTH)
		else $error("internal port width wrong");
	a_slave_port_x1: assert property (readPort == `PORT_PARALLEL_SLAVE && activeMode != `MODE_SLAVE_PARALLEL
		|-> detectedWidthField == `BW_X1)
		else $error("slave port width outside its mode");
	a_word_hold: assert property (wordValid && !wordReady |=> wordValid && $stable(wordOut))
		else $error("stalled word changed");
endmodule : config_front_end_props

bind config_init_and_sync_front_end config_front_end_props #(.INTERNAL_WIDTH(INTERNAL_WIDTH)) i_config_front_end_props (
	.mclk(mclk), .reset_n(reset_n), .programReqN(programReqN), .initStatusIn(initStatusIn),
	.initStatusOe(initStatusOe), .modeSelect(modeSelect), .configClockOe(configClockOe), .userIoHighZ(userIoHighZ),
	.activeMode(activeMode), .spiFlashReadSelect(spiFlashReadSelect), .spiFlashReadCommand(spiFlashReadCommand),
	.readPort(readPort), .detectedWidthField(detectedWidthField), .abortActive(abortActive),
	.syncAlignedFlag(syncAlignedFlag), .wordValid(wordValid), .wordReady(wordReady), .wordOut(wordOut)
);

// [bench/config_source_model.sv]
/*
 * Slave-mode configuration source: link clock and data pins.
 * Assumes the bench calls its tasks one at a time; clock stands low between units.
 */
`timescale 1ns/10ps

module config_source_model (
	output logic configClockIn,
	output logic [31:0] configData
);
	initial begin
		configClockIn = 1'b0;
		configData = 32'h0;
	end

	function automatic logic [7:0] swapByte(input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			swapByte[i] = b[7 - i];
		end
	endfunction : swapByte

	// nBytes 0 is one serial bit on D0
	task automatic sendUnit(input logic [31:0] unit, input int nBytes);
		logic [31:0] pins;
		pins = {{31{~unit[0]}}, unit[0]};
		for (int i = 0; i < nBytes; i++) begin
			pins[8 * i +: 8] = swapByte(unit[8 * i +: 8]);
		end
		configData = pins;
		#80;
		configClockIn = 1'b1;
		#40;
		// Held well past the synchronised edge, then inverted so no stale value lingers
		configData = ~pins;
		#40;
		configClockIn = 1'b0;
	endtask : sendUnit

	// Most significant unit first
	task automatic sendWord(input logic [31:0] word, input int nBytes);
		int units;
		units = (nBytes == 0) ? 32 : 4 / nBytes;
		for (int u = units - 1; u >= 0; u--) begin
			sendUnit(32'(word >> (u * (32 / units))), nBytes);
		end
	endtask : sendWord
endmodule : config_source_model

// [bench/tb_top.sv]
/*
 * Self-checking bench of the configuration front end.
 * Assumes the design, its package and header, the checker and the source model.
 */
`timescale 1ns/10ps
`include "config_init_defines.svh"

module tb_top
	import config_init_pkg::*;
;
	localparam int CLEAR = 4;
	localparam int POR = 8;
	localparam int LAT = 4;
	logic mclk, reset_n, programReqN, jtagReprogramInstr, internalReprogramCmd, fallbackRetry;
	logic initHoldN, initStatusOut, initStatusOe, configClockIn, configClockOut, configClockOe;
	logic userIoHighZ, abortActive, syncAlignedFlag, linkBusy, wordValid, wordReady;
	logic [2:0] modeSelect, flashReadSelect, activeMode, spiFlashReadSelect;
	logic [7:0] flashReadCommand, spiFlashReadCommand;
	logic [31:0] configData;
	logic [1:0] readPort, detectedWidthField;
	config_word_t wordOut;
	wire initStatusIn;
	int seed, fails, checks;

	// Open drain with pull-up, external hold included
	assign initStatusIn = initHoldN && !(initStatusOe && !initStatusOut);

	config_init_and_sync_front_end #(.CLEAR_CYCLES(CLEAR), .POR_CYCLES(POR), .LATENCY_CYCLES(LAT))
	i_config_init_and_sync_front_end (
		.mclk(mclk), .reset_n(reset_n), .programReqN(programReqN), .jtagReprogramInstr(jtagReprogramInstr),
		.internalReprogramCmd(internalReprogramCmd), .fallbackRetry(fallbackRetry), .initStatusIn(initStatusIn),
		.initStatusOut(initStatusOut), .initStatusOe(initStatusOe), .modeSelect(modeSelect),
		.flashReadSelect(flashReadSelect), .flashReadCommand(flashReadCommand), .configClockIn(configClockIn),
		.configClockOut(configClockOut), .configClockOe(configClockOe), .configData(configData),
		.userIoHighZ(userIoHighZ), .activeMode(activeMode), .spiFlashReadSelect(spiFlashReadSelect),
		.spiFlashReadCommand(spiFlashReadCommand), .readPort(readPort), .detectedWidthField(detectedWidthField),
		.abortActive(abortActive), .syncAlignedFlag(syncAlignedFlag), .linkBusy(linkBusy),
		.wordValid(wordValid), .wordReady(wordReady), .wordOut(wordOut)
	);
	config_source_model i_config_source_model (.configClockIn(configClockIn), .configData(configData));

	always #2 mclk = ~mclk;

	task automatic check(input logic ok, input string msg);
		checks++;
		if (ok !== 1'b1) begin
			fails++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask : check

	task automatic close_out();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out

	function automatic logic [1:0] expWidth(input int nBytes);
		case (nBytes)
			1: return `BW_X8;
			2: return `BW_X16;
			4: return `BW_X32;
			default: return `BW_X1;
		endcase
	endfunction : expWidth

	task automatic waitInitDrop(input int expDelay);
		int n;
		n = 0;
		while (initStatusOe === 1'b1 && n < 400) begin
			n++;
			@(negedge mclk);
		end
		check(n >= expDelay - 1 && n <= expDelay + 2, "init release delay");
	endtask : waitInitDrop

	// trig 0 program pin, 1 jtag, 2 internal, 3 fallback
	task automatic restart(input int trig, input logic [2:0] mode);
		int n;
		logic [2:0] fs;
		logic [7:0] cmd;
		logic clk0;
		fs = 3'($random(seed));
		cmd = 8'($random(seed));
		modeSelect = mode;
		flashReadSelect = fs;
		flashReadCommand = cmd;
		if (trig == 0) begin
			programReqN = 1'b0;
			repeat (4 + $unsigned($random(seed)) % 16) @(negedge mclk);
			programReqN = 1'b1;
		end else begin
			{fallbackRetry, internalReprogramCmd, jtagReprogramInstr} = 3'(1 << (trig - 1));
			@(negedge mclk);
			{fallbackRetry, internalReprogramCmd, jtagReprogramInstr} = 3'b000;
		end
		waitInitDrop((trig == 0) ? 2 * CLEAR + LAT + 2 : CLEAR + LAT);
		n = 0;
		while (userIoHighZ === 1'b1 && n < 20) begin
			n++;
			@(negedge mclk);
		end
		check(userIoHighZ === 1'b0, "run not reached");
		check(activeMode === mode, "mode capture");
		check({spiFlashReadSelect, spiFlashReadCommand} === ((mode == `MODE_SPI) ? {fs, cmd} : 11'h0), "spi");
		check(configClockOe === (mode <= `MODE_MASTER_PARALLEL), "clock enable");
		if (mode <= `MODE_MASTER_PARALLEL) begin
			clk0 = configClockOut;
			repeat (`CONFIG_CLOCK_HALF) @(negedge mclk);
			check(configClockOut !== clk0, "config clock idle");
		end
	endtask : restart

	task automatic takeWord(input logic [31:0] d, input int nBytes);
		int n;
		n = 0;
		while (wordValid !== 1'b1 && n < 20000) begin
			n++;
			@(negedge mclk);
		end
		check(wordValid === 1'b1 && wordOut === {d, expWidth(nBytes)}, "word");
		@(negedge mclk);
	endtask : takeWord

	task automatic loadStream(input logic [2:0] mode, input int nBytes, input int trig);
		logic [31:0] d0;
		logic [31:0] d1;
		restart(trig, mode);
		wordReady = 1'b0;
		if (nBytes > 0) begin
			i_config_source_model.sendUnit(32'($random(seed)) & 32'h7f, nBytes);
			i_config_source_model.sendUnit(32'hbb, nBytes);
			i_config_source_model.sendUnit(32'h33, nBytes);
			i_config_source_model.sendWord(`SYNC_WORD, nBytes);
			i_config_source_model.sendUnit(32'hbb, nBytes);
			i_config_source_model.sendUnit(nBytes == 1 ? 32'h11 : nBytes == 2 ? 32'h22 : 32'h44, nBytes);
		end else begin
			i_config_source_model.sendWord({16'hbb11, 16'($random(seed))}, 0);
		end
		i_config_source_model.sendUnit(32'($random(seed)), nBytes);
		i_config_source_model.sendWord(`SYNC_WORD, nBytes);
		d0 = $random(seed);
		d1 = $random(seed);
		i_config_source_model.sendWord(d0, nBytes);
		i_config_source_model.sendWord(d1, nBytes);
		repeat (8) @(negedge mclk);
		check(linkBusy === 1'b1, "buffer not full");
		wordReady = 1'b1;
		takeWord(d0, nBytes);
		takeWord(d1, nBytes);
		check(wordValid === 1'b0, "buffer not empty");
		readPort = `PORT_PARALLEL_SLAVE;
		abortActive = 1'b1;
		@(negedge mclk);
		check(detectedWidthField === (mode == `MODE_SLAVE_PARALLEL ? expWidth(nBytes) : `BW_X1), "slave width");
		check(syncAlignedFlag === (mode == `MODE_SLAVE_PARALLEL), "sync flag");
		readPort = `PORT_JTAG;
		abortActive = 1'b0;
		@(negedge mclk);
		check(detectedWidthField === expWidth(nBytes), "jtag width");
		check(syncAlignedFlag === 1'b0, "flag outside abort");
		readPort = 2'b11;
		@(negedge mclk);
		check(detectedWidthField === `BW_X1, "no port width");
		readPort = `PORT_INTERNAL;
		@(negedge mclk);
		check(detectedWidthField === `INTERNAL_PORT_WIDTH, "internal width");
	endtask : loadStream

	initial begin
		#200000;
		fails++;
		$display("MISMATCH %0t watchdog expired", $time);
		close_out();
	end

	initial begin
		mclk = 1'b0;
		seed = 33157;
		{reset_n, jtagReprogramInstr, internalReprogramCmd, fallbackRetry, initHoldN, abortActive} = 6'h0;
		{programReqN, wordReady} = 2'b11;
		{modeSelect, flashReadSelect, flashReadCommand} = 14'h0;
		readPort = `PORT_INTERNAL;
		repeat (3) @(negedge mclk);
		reset_n = 1'b1;
		waitInitDrop(CLEAR + POR);
		repeat (20) @(negedge mclk);
		check(userIoHighZ === 1'b1, "run while init held");
		initHoldN = 1'b1;
		for (int m = 0; m < 8; m++) begin
			restart(m % 4, 3'(m));
		end
		loadStream(`MODE_SLAVE_PARALLEL, 1, 0);
		loadStream(`MODE_SLAVE_PARALLEL, 2, 0);
		loadStream(`MODE_SLAVE_PARALLEL, 4, 0);
		loadStream(`MODE_SLAVE_SERIAL, 0, 1);
		close_out();
	end
endmodule : tb_top
